//--- rtl/host_port_pkg.sv
package host_port_pkg;

  localparam int ADDR_W   = 15;
  localparam int DATA_W   = 8;
  localparam int NUM_OUT  = 16;
  localparam int NUM_GPIO = 3;
  localparam int PIN_W    = 11;

  // Positions of the pins in the synchroniser vector.
  localparam int PIN_PD   = 0;
  localparam int PIN_SEL  = 1;
  localparam int PIN_PGA  = 2;
  localparam int PIN_PGB  = 3;
  localparam int PIN_LV0  = 4;
  localparam int PIN_LV1  = 5;
  localparam int PIN_CS   = 6;
  localparam int PIN_SCK  = 7;
  localparam int PIN_SDIO = 8;
  localparam int PIN_SCL  = 9;
  localparam int PIN_SDA  = 10;

  // Serial frame bit counts.
  localparam logic [4:0] HDR_LAST   = 5'h0f;
  localparam logic [4:0] DATA_FIRST = 5'h10;
  localparam logic [4:0] BYTE_LAST  = 5'h17;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [1:0] IDX_DATA   = 2'h2;

  localparam logic [ADDR_W-1:0] SYNC_REG_ADDR = 15'h0015;
  localparam int                SYNC_BIT      = 6;

  // Target address upper bits and address pin levels.
  localparam logic [4:0] NV_ADDR_MSB_DEFAULT = 5'h19;
  localparam logic [1:0] LVL_HIGH  = 2'h2;
  localparam logic [1:0] LVL_BAD   = 2'h3;
  localparam logic [1:0] PAGE_NONE = 2'h0;

  typedef enum logic [2:0] {
    I_IDLE,
    I_ADDR,
    I_ACK,
    I_WRITE,
    I_READ,
    I_RACK
  } i2c_state_e;

  function automatic logic rise_of(input logic now, input logic was);
    rise_of = now & ~was;
  endfunction

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // Pins in, synchronised levels out.
  input  wire logic [host_port_pkg::PIN_W-1:0] pin_in,
  output logic      [host_port_pkg::PIN_W-1:0] pin_s
);
  import host_port_pkg::*;

  logic [PIN_W-1:0] meta_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      pin_s  <= '0;
    end else begin
      meta_r <= pin_in;
      pin_s  <= meta_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

//--- rtl/i2c_target_port.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_target_port (
  // Clock and reset.
  input  wire logic                               clk,
  input  wire logic                               reset_n,
  // Control and synchronised bus levels.
  input  wire logic                               enable,
  input  wire logic                               scl_s,
  input  wire logic                               sda_s,
  input  wire logic [6:0]                         target_addr,
  // Read data return.
  input  wire logic [host_port_pkg::DATA_W-1:0]   rd_data,
  input  wire logic                               rd_valid,
  // Register access requests.
  output logic                                    wr_en,
  output logic                                    rd_en,
  output logic      [host_port_pkg::ADDR_W-1:0]   acc_addr,
  output logic      [host_port_pkg::DATA_W-1:0]   wr_data,
  output logic                                    sda_low
);
  import host_port_pkg::*;

  i2c_state_e  state_r;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        rw_r;
  logic        hit_r;
  logic        done_r;
  logic [2:0]  bit_r;
  logic [1:0]  idx_r;
  logic [7:0]  sr_r;
  logic [7:0]  out_r;

  wire       scl_rise = rise_of(scl_s, scl_d_r);
  wire       scl_fall = rise_of(scl_d_r, scl_s);
  wire       start    = scl_s & scl_d_r & rise_of(sda_d_r, sda_s);
  wire       stop     = scl_s & scl_d_r & rise_of(sda_s, sda_d_r);
  wire       last     = (bit_r == BIT_LAST);
  wire [7:0] byte_in  = {sr_r[6:0], sda_s};
  wire       addr_hit = (byte_in[7:1] == target_addr);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= I_IDLE;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      rw_r     <= 1'b0;
      hit_r    <= 1'b0;
      done_r   <= 1'b0;
      bit_r    <= '0;
      idx_r    <= '0;
      sr_r     <= '0;
      out_r    <= '0;
      wr_en    <= 1'b0;
      rd_en    <= 1'b0;
      acc_addr <= '0;
      wr_data  <= '0;
      sda_low  <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_en   <= 1'b0;
      rd_en   <= 1'b0;
      if (rd_valid) out_r <= rd_data;
      if (wr_en) acc_addr <= acc_addr + 1'b1; // RULE23
      if (!enable || stop) begin
        state_r <= I_IDLE;
        sda_low <= 1'b0;
        done_r  <= 1'b0;
      end else if (start) begin
        state_r <= I_ADDR;
        bit_r   <= '0;
        idx_r   <= '0;
        sda_low <= 1'b0;
        done_r  <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          I_ADDR, I_WRITE: begin
            sr_r  <= byte_in;
            bit_r <= bit_r + 1'b1;
            if (last) begin
              done_r <= 1'b1;
              if (state_r == I_ADDR) begin
                hit_r <= addr_hit; // RULE2
                rw_r  <= sda_s;
                rd_en <= addr_hit & sda_s;
              end else begin
                hit_r <= 1'b1;
                case (idx_r) // RULE4
                  2'h0: acc_addr[ADDR_W-1:DATA_W] <= byte_in[6:0];
                  2'h1: acc_addr[DATA_W-1:0] <= byte_in;
                  default: begin
                    wr_en   <= 1'b1; // RULE7
                    wr_data <= byte_in;
                  end
                endcase
                if (idx_r != IDX_DATA) idx_r <= idx_r + 1'b1;
              end
            end
          end
          I_READ: begin
            bit_r <= bit_r + 1'b1;
            if (last) state_r <= I_RACK;
          end
          I_RACK: begin
            if (!sda_s) begin
              state_r  <= I_READ;
              bit_r    <= '0;
              acc_addr <= acc_addr + 1'b1; // RULE23
              rd_en    <= 1'b1; // RULE7
            end else begin
              state_r <= I_IDLE;
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_r)
          I_ADDR, I_WRITE: begin
            if (done_r) begin
              done_r  <= 1'b0;
              state_r <= hit_r ? I_ACK : I_IDLE;
              sda_low <= hit_r;
            end
          end
          I_ACK: begin
            bit_r   <= '0;
            state_r <= rw_r ? I_READ : I_WRITE;
            sda_low <= rw_r & ~out_r[7];
            if (rw_r) out_r <= {out_r[6:0], 1'b1};
          end
          I_READ: begin
            sda_low <= ~out_r[7];
            out_r   <= {out_r[6:0], 1'b1};
          end
          I_RACK: sda_low <= 1'b0;
          default: ;
        endcase
      end
    end
  end
endmodule // i2c_target_port
`default_nettype wire

//--- rtl/host_serial_register_port.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1: Low select strap gives I2C target, 100/400 kHz.
// RULE2: Address: five stored bits, two pin bits.
// RULE3: Default storage, pin levels give 0x64..0x66.
// RULE4: Two address bytes, then one-byte data.
// RULE5: One register map behind both interfaces.
// RULE6: Access works whenever power-down is released.
// RULE7: I2C block reads and writes supported.
// RULE8: I2C mode: page straps choose ROM page.
// RULE9: Three-wire shared pin, or GPIO readback.
// RULE10: Chip select also triggers elapsed time counter.
// RULE11: Readback output may be open drain.
// RULE12: Host sends flag, address, data, MSB first.
// RULE13: Flag zero writes, flag one reads.
// RULE14: Chip select low frames; first bit flag.
// RULE15: Write byte commits on its last rising edge.
// RULE16: Partial trailing bits never reach a register.
// RULE17: Read bits leave on falling clock edges.
// RULE18: Block frame: two address bytes, N data.
// RULE19: Address increments after every further byte.
// RULE20: Host skips the reset control register.
// RULE21: Host pulses the output sync bit.
// RULE22: Outputs without sync enable ignore sync.
// RULE23: I2C block transfers auto-increment too.
module host_serial_register_port (
  // Clock and reset.
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  // Power-down and start-up straps.
  input  wire logic                                 power_down_n,
  input  wire logic                                 interface_select_strap,
  input  wire logic                                 rom_page_strap_a,
  input  wire logic                                 rom_page_strap_b,
  input  wire logic [1:0]                           address_select_level,
  // Stored upper bits of the I2C target address.
  input  wire logic [4:0]                           nv_addr_msbs,
  input  wire logic                                 nv_addr_valid,
  // SPI pins.
  input  wire logic                                 address_select_pin,
  input  wire logic                                 sck,
  input  wire logic                                 sdio_in,
  output logic                                      sdio_out,
  output logic                                      sdio_oe,
  output logic      [host_port_pkg::NUM_GPIO-1:0]   gpio_out,
  output logic      [host_port_pkg::NUM_GPIO-1:0]   gpio_oe,
  // I2C pins.
  input  wire logic                                 scl_in,
  input  wire logic                                 sda_in,
  output logic                                      sda_out,
  output logic                                      sda_oe,
  // Configuration.
  input  wire logic                                 three_wire_disable,
  input  wire logic [1:0]                           sdo_gpio_select,
  input  wire logic                                 sdo_open_drain,
  input  wire logic                                 tec_trigger_enable,
  input  wire logic [host_port_pkg::NUM_OUT-1:0]    output_sync_enable,
  // Register map access.
  output logic      [host_port_pkg::ADDR_W-1:0]     reg_addr,
  output logic      [host_port_pkg::DATA_W-1:0]     reg_wr_data,
  output logic                                      reg_wr_en,
  output logic                                      reg_rd_en,
  input  wire logic [host_port_pkg::DATA_W-1:0]     reg_rd_data,
  // Status.
  output logic                                      straps_valid,
  output logic                                      i2c_mode,
  output logic      [1:0]                           rom_page,
  output logic      [6:0]                           i2c_target_addr,
  output logic                                      elapsed_time_trigger,
  output logic                                      output_divider_sync,
  output logic      [host_port_pkg::NUM_OUT-1:0]    output_sync_hold
);
  import host_port_pkg::*;

  localparam logic [NUM_GPIO-1:0] GPIO_ONE = 3'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [PIN_W-1:0] pin_in;
  logic [PIN_W-1:0] pin_s;

  assign pin_in[PIN_PD]   = power_down_n;
  assign pin_in[PIN_SEL]  = interface_select_strap;
  assign pin_in[PIN_PGA]  = rom_page_strap_a;
  assign pin_in[PIN_PGB]  = rom_page_strap_b;
  assign pin_in[PIN_LV0]  = address_select_level[0];
  assign pin_in[PIN_LV1]  = address_select_level[1];
  assign pin_in[PIN_CS]   = address_select_pin;
  assign pin_in[PIN_SCK]  = sck;
  assign pin_in[PIN_SDIO] = sdio_in;
  assign pin_in[PIN_SCL]  = scl_in;
  assign pin_in[PIN_SDA]  = sda_in;

  pin_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (pin_in),
    .pin_s   (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up strap capture.

  wire       pd_ok   = pin_s[PIN_PD];
  wire       sel_i2c = ~pin_s[PIN_SEL];
  wire [1:0] lvl_s   = {pin_s[PIN_LV1], pin_s[PIN_LV0]};
  wire [1:0] addr_lsb = (lvl_s == LVL_BAD) ? LVL_HIGH : lvl_s;
  wire [4:0] addr_msb = nv_addr_valid ? nv_addr_msbs : NV_ADDR_MSB_DEFAULT;

  // Straps are taken on the third clock edge after power-down is released, once the release has passed the synchroniser.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      straps_valid    <= 1'b0;
      i2c_mode        <= 1'b0;
      rom_page        <= PAGE_NONE;
      i2c_target_addr <= '0;
    end else if (!pd_ok) begin
      straps_valid <= 1'b0;
    end else if (!straps_valid) begin
      straps_valid    <= 1'b1;
      i2c_mode        <= sel_i2c; // RULE1
      rom_page        <= sel_i2c ? {pin_s[PIN_PGB], pin_s[PIN_PGA]} : PAGE_NONE; // RULE8
      i2c_target_addr <= {addr_msb, addr_lsb}; // RULE2 RULE3
    end
  end

  wire spi_on = straps_valid & ~i2c_mode & pd_ok; // RULE6
  wire i2c_on = straps_valid & i2c_mode & pd_ok; // RULE6

  ////////////////////////////////////////////////////////////////////////////////
  // SPI target.

  logic              sck_d_r;
  logic              cs_d_r;
  logic [4:0]        cnt_r;
  logic              rw_r;
  logic [ADDR_W-1:0] ptr_r;
  logic [7:0]        in_r;
  logic [7:0]        out_r;
  logic              drive_r;
  logic              sdo_bit_r;
  logic              rd_ack_r;

  wire cs_act    = spi_on & ~pin_s[PIN_CS]; // RULE14
  wire sck_rise  = cs_act & rise_of(pin_s[PIN_SCK], sck_d_r);
  wire sck_fall  = cs_act & rise_of(sck_d_r, pin_s[PIN_SCK]);
  wire bit_in    = pin_s[PIN_SDIO];
  wire hdr_done  = (cnt_r == HDR_LAST);
  wire byte_done = (cnt_r == BYTE_LAST);
  wire in_data   = (cnt_r >= DATA_FIRST);

  wire [ADDR_W-1:0] hdr_addr = {ptr_r[ADDR_W-2:0], bit_in};
  wire [ADDR_W-1:0] inc_addr = ptr_r + 1'b1;
  wire              spi_rd   = sck_rise & rw_r & (hdr_done | byte_done); // RULE13
  wire              spi_wr   = sck_rise & ~rw_r & byte_done; // RULE13 RULE15 RULE16
  wire [ADDR_W-1:0] spi_addr = spi_wr ? ptr_r : (hdr_done ? hdr_addr : inc_addr);
  wire [7:0]        spi_data = {in_r[6:0], bit_in};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_r   <= 1'b0;
      cnt_r     <= '0;
      rw_r      <= 1'b0;
      ptr_r     <= '0;
      in_r      <= '0;
      drive_r   <= 1'b0;
      sdo_bit_r <= 1'b1;
    end else begin
      sck_d_r <= pin_s[PIN_SCK];
      if (!cs_act) begin
        cnt_r   <= '0; // RULE16
        drive_r <= 1'b0;
      end else begin
        if (sck_rise) begin
          in_r  <= spi_data;
          cnt_r <= byte_done ? DATA_FIRST : cnt_r + 1'b1;
          if (cnt_r == '0) begin
            rw_r <= bit_in; // RULE14 RULE12
          end else if (cnt_r <= HDR_LAST) begin
            ptr_r <= hdr_addr;
          end else if (byte_done) begin
            ptr_r <= inc_addr; // RULE19 RULE18
          end
        end
        if (sck_fall & rw_r & in_data) begin
          drive_r   <= 1'b1;
          sdo_bit_r <= out_r[7]; // RULE17
        end
      end
    end
  end

  // Read data shift register; loaded when the register map answers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_r <= '0;
    end else if (rd_ack_r & ~i2c_mode) begin
      out_r <= reg_rd_data;
    end else if (sck_fall & rw_r & in_data) begin
      out_r <= {out_r[6:0], 1'b0}; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // I2C target.

  logic              i2c_wr;
  logic              i2c_rd;
  logic [ADDR_W-1:0] i2c_addr;
  logic [DATA_W-1:0] i2c_data;
  logic              i2c_low;

  i2c_target_port u_i2c (
    .clk         (clk),
    .reset_n     (reset_n),
    .enable      (i2c_on),
    .scl_s       (pin_s[PIN_SCL]),
    .sda_s       (pin_s[PIN_SDA]),
    .target_addr (i2c_target_addr),
    .rd_data     (reg_rd_data),
    .rd_valid    (rd_ack_r & i2c_mode),
    .wr_en       (i2c_wr),
    .rd_en       (i2c_rd),
    .acc_addr    (i2c_addr),
    .wr_data     (i2c_data),
    .sda_low     (i2c_low)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shared register map access.

  wire              acc_wr   = i2c_mode ? i2c_wr : spi_wr; // RULE5
  wire              acc_rd   = i2c_mode ? i2c_rd : spi_rd; // RULE5
  wire [ADDR_W-1:0] acc_addr = i2c_mode ? i2c_addr : spi_addr;
  wire [DATA_W-1:0] acc_data = i2c_mode ? i2c_data : spi_data;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_addr    <= '0;
      reg_wr_data <= '0;
      reg_wr_en   <= 1'b0;
      reg_rd_en   <= 1'b0;
      rd_ack_r    <= 1'b0;
    end else begin
      reg_wr_en <= acc_wr;
      reg_rd_en <= acc_rd;
      rd_ack_r  <= reg_rd_en;
      if (acc_wr | acc_rd) begin
        reg_addr    <= acc_addr;
        reg_wr_data <= acc_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output divider synchronisation.

  wire sync_wr = reg_wr_en & (reg_addr == SYNC_REG_ADDR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      output_divider_sync <= 1'b0;
      output_sync_hold    <= '0;
    end else begin
      if (sync_wr) output_divider_sync <= reg_wr_data[SYNC_BIT];
      output_sync_hold <= {NUM_OUT{output_divider_sync}} & output_sync_enable; // RULE22
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Elapsed time counter trigger from the chip select pin.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_d_r               <= 1'b1;
      elapsed_time_trigger <= 1'b0;
    end else begin
      cs_d_r               <= pin_s[PIN_CS];
      elapsed_time_trigger <= spi_on & tec_trigger_enable & rise_of(cs_d_r, pin_s[PIN_CS]); // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  // Open drain drives only the low level and lets the pull-up make the high.
  wire sdo_val = sdo_open_drain ? 1'b0 : sdo_bit_r; // RULE11
  wire sdo_oe  = drive_r & (~sdo_open_drain | ~sdo_bit_r); // RULE11
  wire [NUM_GPIO-1:0] gpio_hot = GPIO_ONE << sdo_gpio_select;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
      gpio_out <= '0;
      gpio_oe  <= '0;
      sda_out  <= 1'b0;
      sda_oe   <= 1'b0;
    end else begin
      sdio_out <= sdo_val;
      sdio_oe  <= sdo_oe & ~three_wire_disable; // RULE9
      gpio_out <= {NUM_GPIO{sdo_val}} & gpio_hot;
      gpio_oe  <= {NUM_GPIO{sdo_oe & three_wire_disable}} & gpio_hot; // RULE9
      sda_out  <= 1'b0;
      sda_oe   <= i2c_low & i2c_on;
    end
  end

endmodule // host_serial_register_port
`default_nettype wire

//--- test/host_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
module host_port_sva (
  // Clock and reset.
  input wire logic                              clk,
  input wire logic                              reset_n,
  // Pins and configuration.
  input wire logic                              power_down_n,
  input wire logic                              interface_select_strap,
  input wire logic                              address_select_pin,
  input wire logic                              three_wire_disable,
  input wire logic                              sdo_open_drain,
  input wire logic                              tec_trigger_enable,
  input wire logic [host_port_pkg::NUM_OUT-1:0] output_sync_enable,
  // Outputs watched.
  input wire logic                              sdio_out,
  input wire logic                              sdio_oe,
  input wire logic [host_port_pkg::NUM_GPIO-1:0] gpio_out,
  input wire logic [host_port_pkg::NUM_GPIO-1:0] gpio_oe,
  input wire logic                              reg_wr_en,
  input wire logic                              reg_rd_en,
  input wire logic                              straps_valid,
  input wire logic                              i2c_mode,
  input wire logic                              elapsed_time_trigger,
  input wire logic                              output_divider_sync,
  input wire logic [host_port_pkg::NUM_OUT-1:0] output_sync_hold
);
  import host_port_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Chip select falling while the SPI port is live.
  sequence s_cs_fall;
    $fell(address_select_pin) ##0 (straps_valid && !i2c_mode && tec_trigger_enable);
  endsequence
  sequence s_trigger;
    ##[2:8] elapsed_time_trigger;
  endsequence

  a_tec_follows_cs: assert property (s_cs_fall |-> s_trigger)
    else $error("no elapsed time trigger after chip select fell");
  a_tec_cause: assert property (elapsed_time_trigger |-> tec_trigger_enable && !i2c_mode)
    else $error("elapsed time trigger without cause");
  a_wr_strobe_pulse: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write strobe longer than one cycle");
  a_rd_strobe_pulse: assert property (reg_rd_en |=> !reg_rd_en)
    else $error("read strobe longer than one cycle");
  a_pd_quiet: assert property (!power_down_n [*4] |-> !straps_valid && !reg_wr_en && !reg_rd_en)
    else $error("activity while powered down");
  a_strobe_needs_up: assert property ((reg_wr_en || reg_rd_en) |-> straps_valid && power_down_n)
    else $error("register access before start-up");
  a_mode_strap: assert property ($rose(straps_valid) |-> ##1 i2c_mode == !interface_select_strap)
    else $error("interface mode does not follow strap");
  a_od_low_only: assert property (sdo_open_drain |-> !(sdio_oe && sdio_out) && (gpio_oe & gpio_out) == 3'h0)
    else $error("open drain output drove high");
  a_wire_choice: assert property (three_wire_disable ? !sdio_oe : gpio_oe == 3'h0)
    else $error("readback on the wrong pin");
  a_sdio_release: assert property (address_select_pin [*8] |-> !sdio_oe)
    else $error("data pin driven outside a frame");
  a_sync_hold: assert property (1'b1 |=> output_sync_hold ==
      ($past(output_divider_sync) ? $past(output_sync_enable) : {NUM_OUT{1'b0}}))
    else $error("sync hold does not follow enables");
endmodule // host_port_sva

bind host_serial_register_port host_port_sva u_sva (.clk, .reset_n, .power_down_n, .interface_select_strap,
  .address_select_pin, .three_wire_disable, .sdo_open_drain, .tec_trigger_enable, .output_sync_enable,
  .sdio_out, .sdio_oe, .gpio_out, .gpio_oe, .reg_wr_en, .reg_rd_en, .straps_valid, .i2c_mode,
  .elapsed_time_trigger, .output_divider_sync, .output_sync_hold);
`default_nettype wire

//--- test/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  // Clock.
  input  wire logic clk,
  // Serial lines.
  output logic      cs_n,
  output logic      sck,
  output logic      mosi,
  output logic      mosi_oe,
  input  wire logic miso
);
  initial begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    mosi    = 1'b0;
    mosi_oe = 1'b0;
  end

  // Half a serial clock period, ten system clocks, changed just after an edge.
  task automatic half();
    repeat (10) @(posedge clk);
    #1;
  endtask

  // Sends n bits from the top of bits; on reads the line is let go after the header.
  task automatic frame(input logic [55:0] bits, input int n, output logic [31:0] rx);
    rx   = 32'h0;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_oe = !(bits[55] && i >= 16);
      mosi    = bits[55-i];
      half();
      sck = 1'b1;
      rx  = {rx[30:0], miso};
      half();
      sck = 1'b0;
    end
    mosi_oe = 1'b0;
    half();
    cs_n = 1'b1;
    half();
  endtask
endmodule // spi_host_model
`default_nettype wire

//--- test/host_serial_register_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module host_serial_register_port_tb;
  import host_port_pkg::*;

  logic        clk, reset_n, power_down_n, interface_select_strap, rom_page_strap_a, rom_page_strap_b;
  logic [1:0]  address_select_level, sdo_gpio_select, rom_page;
  logic [4:0]  nv_addr_msbs;
  logic        nv_addr_valid, three_wire_disable, sdo_open_drain, tec_trigger_enable;
  logic [15:0] output_sync_enable, output_sync_hold;
  logic        cs_n, sck, mosi, mosi_oe, sdio_out, sdio_oe, sda_out, sda_oe;
  logic [2:0]  gpio_out, gpio_oe;
  logic [14:0] reg_addr;
  logic [7:0]  reg_wr_data;
  logic        reg_wr_en, reg_rd_en, straps_valid, i2c_mode, elapsed_time_trigger, output_divider_sync;
  logic [6:0]  i2c_target_addr;
  logic [7:0]  mem [0:15] = '{default: 8'h00};
  logic [7:0]  rd_q = 8'h00;
  logic [31:0] rx;
  logic [6:0]  exp_addr;
  int          wr_count = 0;
  int          err_count = 0;
  int          samples_checked = 0;
  wire logic   sdio_line = sdio_oe ? sdio_out : (mosi_oe ? mosi : 1'b1);
  wire logic   miso = three_wire_disable ? (gpio_oe[1] ? gpio_out[1] : 1'b1) : sdio_line;

  host_serial_register_port dut (.clk, .reset_n, .power_down_n, .interface_select_strap, .rom_page_strap_a,
    .rom_page_strap_b, .address_select_level, .nv_addr_msbs, .nv_addr_valid, .address_select_pin(cs_n),
    .sck, .sdio_in(sdio_line), .sdio_out, .sdio_oe, .gpio_out, .gpio_oe, .scl_in(1'b1), .sda_in(1'b1),
    .sda_out, .sda_oe, .three_wire_disable, .sdo_gpio_select, .sdo_open_drain, .tec_trigger_enable,
    .output_sync_enable, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en, .reg_rd_data(rd_q),
    .straps_valid, .i2c_mode, .rom_page, .i2c_target_addr, .elapsed_time_trigger, .output_divider_sync,
    .output_sync_hold);
  spi_host_model host (.clk, .cs_n, .sck, .mosi, .mosi_oe, .miso);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Register map stand-in; read data is ready in the cycle after the strobe.
  always @(posedge clk) begin
    if (reg_wr_en) begin
      mem[reg_addr[3:0]] <= reg_wr_data;
      wr_count <= wr_count + 1;
    end
    if (reg_rd_en) rd_q <= mem[reg_addr[3:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Power-down pulse, then wait for the straps to be taken.
  task automatic power_up();
    int n;
    n = 0;
    power_down_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 power_down_n = 1'b1;
    while (straps_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    cmp_val({15'h0, straps_valid}, 16'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    power_down_n = 1'b0;
    interface_select_strap = 1'b0;
    rom_page_strap_a = 1'b1;
    rom_page_strap_b = 1'b1;
    address_select_level = 2'h0;
    nv_addr_msbs = 5'h0a;
    nv_addr_valid = 1'b0;
    three_wire_disable = 1'b0;
    sdo_gpio_select = 2'h1;
    sdo_open_drain = 1'b0;
    tec_trigger_enable = 1'b0;
    output_sync_enable = 16'h00f3;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int l = 0; l < 3; l++) begin
      address_select_level = 2'(l);
      nv_addr_valid = (l == 2);
      exp_addr = (l == 2) ? 7'h2a : 7'h64 + 7'(l);
      power_up();
      cmp_val({9'h0, i2c_target_addr}, {9'h0, exp_addr});
      cmp_val({15'h0, i2c_mode}, 16'h1);
      cmp_val({14'h0, rom_page}, 16'h3);
    end
    host.frame({1'b0, 15'h0003, 8'h77, 32'h0}, 24, rx);
    cmp_val(16'(wr_count), 16'h0);
    interface_select_strap = 1'b1;
    tec_trigger_enable = 1'b1;
    power_up();
    cmp_val({15'h0, i2c_mode}, 16'h0);
    host.frame({1'b0, 15'h0003, 8'ha5, 32'h0}, 24, rx);
    cmp_val({8'h0, mem[3]}, 16'h00a5);
    host.frame({1'b0, 15'h0005, 24'h112233, 16'h0}, 40, rx);
    cmp_val({mem[5], mem[6]}, 16'h1122);
    cmp_val({8'h0, mem[7]}, 16'h0033);
    host.frame({1'b0, 15'h0008, 8'h5a, 5'h1f, 27'h0}, 29, rx);
    cmp_val({mem[8], mem[9]}, 16'h5a00);
    cmp_val(16'(wr_count), 16'h5);
    host.frame({1'b1, 15'h0005, 40'h0}, 32, rx);
    cmp_val(rx[15:0], 16'h1122);
    three_wire_disable = 1'b1;
    sdo_open_drain = 1'b1;
    host.frame({1'b1, 15'h0003, 40'h0}, 24, rx);
    cmp_val({8'h0, rx[7:0]}, 16'h00a5);
    host.frame({1'b0, SYNC_REG_ADDR, 8'h40, 32'h0}, 24, rx);
    cmp_val({15'h0, output_divider_sync}, 16'h1);
    cmp_val(output_sync_hold, 16'h00f3);
    host.frame({1'b0, SYNC_REG_ADDR, 8'h00, 32'h0}, 24, rx);
    cmp_val({output_divider_sync, output_sync_hold[14:0]}, 16'h0);
    tally_and_finish();
  end

  initial begin
    #2000000;
    err_count++;
    tally_and_finish();
  end
endmodule // host_serial_register_port_tb
`default_nettype wire
